/* File: adc_trig_pkg.sv */
// Package with register map, field layout and shared types of the sample and convert trigger block.
package adc_trig_pkg;

   // Register offsets on the plain register port.
   localparam logic [3:0] CTRL_OFFSET   = 4'h0;
   localparam logic [3:0] STATUS_OFFSET = 4'h1;
   localparam logic [3:0] MASK_OFFSET   = 4'h2;
   localparam logic [3:0] CFG_OFFSET    = 4'h3;

   // Field positions within the control register.
   localparam int DONE_BIT    = 0;
   localparam int SAMPLE_ENABLE_BIT_BIT    = 1;
   localparam int AUTO_START_SAMPLING_BIT    = 2;
   localparam int SIMSEL_BIT  = 3;
   localparam int GROUP_BIT   = 4;
   localparam int SRC_LO      = 5;
   localparam int SRC_HI      = 7;

   // Field positions within the configuration register.
   localparam int CHCNT_LO    = 0;
   localparam int CHCNT_HI    = 1;
   localparam int TWELVE_BIT  = 2;

   // Status bits (sticky events).
   localparam int EV_DONE     = 0;
   localparam int EV_START    = 1;
   localparam int EV_IGNORED  = 2;
   localparam int EV_WIDTH    = 3;

   // Reset values.
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] CFG_RESET  = 16'h0000;
   localparam logic [EV_WIDTH-1:0] MASK_RESET = 3'h0;

   // Default cycle counts (module parameters take these).
   localparam int AUTO_COUNT_DEFAULT = 16;
   localparam int CONV_COUNT_DEFAULT = 14;

   // Trigger source inputs from the surrounding chip.
   typedef struct packed {
      logic       pattern_trigger_out_12;
      logic       pattern_trigger_out_13;
      logic       pattern_trigger_out_14;
      logic       pattern_trigger_out_15;
      logic [2:0] pwm_gen_primary;
      logic       charge_time_unit;
      logic       pwm_secondary_event;
      logic       timer5_compare;
      logic       pwm_primary_event;
      logic       timer3_compare;
      logic       ext_int0_pin;
   } trig_src_t;

   // Sample and hold control towards the converter.
   typedef struct packed {
      logic       sampling;
      logic       convert_start;
      logic [3:0] sample_together;
      logic [3:0] channel_enable;
   } sh_ctrl_t;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_SAMPLE = 3'b010,
      ST_CONV   = 3'b100
   } phase_t;

endpackage

/* File: adc_sample_convert_trigger.sv */
// Sample and convert trigger control for a sample-and-hold converter.
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module adc_sample_convert_trigger
   import adc_trig_pkg::*;
#(
   parameter int AUTO_COUNT = AUTO_COUNT_DEFAULT,
   parameter int CONV_COUNT = CONV_COUNT_DEFAULT
)(
   input  wire logic        SYS_CLK_IN,
   input  wire logic        RST_IN,
   input  wire logic [3:0]  ADDR_IN,
   input  wire logic [15:0] WDATA_IN,
   input  wire logic        WR_IN,
   input  wire logic        RD_IN,
   input  wire trig_src_t   TRIG_IN,
   output logic [15:0]      RDATA_OUT,
   output sh_ctrl_t         SH_OUT,
   output logic             IRQ_OUT
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers and state.
   logic [2:0]          src_code;
   logic                group_sel;
   logic                simultaneous_sample_sel;
   logic                auto_start;
   logic                sample_en;
   logic                done;
   logic [1:0]          chan_count;
   logic                twelve_bit;
   logic [EV_WIDTH-1:0] status;
   logic [EV_WIDTH-1:0] mask;
   phase_t              phase;
   logic [15:0]         auto_cnt;
   logic [15:0]         conv_cnt;
   trig_src_t           trig_prev;

   logic                wr_ctrl;
   logic                sel_trig;
   logic                start_conv;
   logic                conv_end;
   logic                eff_simultaneous_sample_sel;
   logic [EV_WIDTH-1:0] events;

   // Rising edge of one source bit; sources are pulses or levels, so edges are used.
   function automatic logic rise(input logic now, input logic was);
      rise = now & ~was;
   endfunction

   assign wr_ctrl    = WR_IN && (ADDR_IN == CTRL_OFFSET);
   // Simultaneous sampling only counts with two or more channels and outside 12-bit mode.
   assign eff_simultaneous_sample_sel = simultaneous_sample_sel && !twelve_bit && (chan_count != 2'b00);

   ////////////////////////////////////////////////////////////////////////////
   // Trigger selection.
   always_comb begin
      sel_trig = 1'b0;
      if (group_sel) begin
         unique case (src_code)
            3'b000:  sel_trig = rise(TRIG_IN.pwm_gen_primary[0], trig_prev.pwm_gen_primary[0]);
            3'b001:  sel_trig = rise(TRIG_IN.pwm_gen_primary[1], trig_prev.pwm_gen_primary[1]);
            3'b010:  sel_trig = rise(TRIG_IN.pwm_gen_primary[2], trig_prev.pwm_gen_primary[2]);
            3'b011:  sel_trig = rise(TRIG_IN.pattern_trigger_out_12, trig_prev.pattern_trigger_out_12);
            3'b100:  sel_trig = rise(TRIG_IN.pattern_trigger_out_13, trig_prev.pattern_trigger_out_13);
            3'b101:  sel_trig = rise(TRIG_IN.pattern_trigger_out_14, trig_prev.pattern_trigger_out_14);
            3'b110:  sel_trig = rise(TRIG_IN.pattern_trigger_out_15, trig_prev.pattern_trigger_out_15);
            3'b111:  sel_trig = 1'b0; // Reserved code never triggers.
         endcase
      end else begin
         unique case (src_code)
            3'b000:  sel_trig = 1'b0; // Manual mode is handled by the write path.
            3'b001:  sel_trig = rise(TRIG_IN.ext_int0_pin, trig_prev.ext_int0_pin);
            3'b010:  sel_trig = rise(TRIG_IN.timer3_compare, trig_prev.timer3_compare);
            3'b011:  sel_trig = rise(TRIG_IN.pwm_primary_event, trig_prev.pwm_primary_event);
            3'b100:  sel_trig = rise(TRIG_IN.timer5_compare, trig_prev.timer5_compare);
            3'b101:  sel_trig = rise(TRIG_IN.pwm_secondary_event, trig_prev.pwm_secondary_event);
            3'b110:  sel_trig = rise(TRIG_IN.charge_time_unit, trig_prev.charge_time_unit);
            3'b111:  sel_trig = (auto_cnt == 16'(AUTO_COUNT - 1));
         endcase
      end
   end

   // A conversion starts only from sampling; in manual mode by writing the sample bit to zero.
   always_comb begin
      start_conv = 1'b0;
      if (phase == ST_SAMPLE) begin
         if (src_code == 3'b000 && !group_sel)
            start_conv = wr_ctrl && !WDATA_IN[SAMPLE_ENABLE_BIT_BIT];
         else
            start_conv = sel_trig;
      end
   end

   assign conv_end = (phase == ST_CONV) && (conv_cnt == 16'(CONV_COUNT - 1));
   assign events   = {(sel_trig && phase != ST_SAMPLE), start_conv, conv_end};

   // Edge history of the trigger sources.
   always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
      if (RST_IN)
         trig_prev <= '0;
      else
         trig_prev <= TRIG_IN;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Phase sequencer and cycle counters.
   always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         phase    <= ST_IDLE;
         auto_cnt <= 16'h0000;
         conv_cnt <= 16'h0000;
      end else begin
         unique case (phase)
            ST_IDLE: begin
               auto_cnt <= 16'h0000;
               if (sample_en || (wr_ctrl && WDATA_IN[SAMPLE_ENABLE_BIT_BIT]))
                  phase <= ST_SAMPLE;
            end
            ST_SAMPLE: begin
               auto_cnt <= auto_cnt + 16'h0001; // Sample time for auto-convert.
               if (start_conv) begin
                  phase    <= ST_CONV;
                  conv_cnt <= 16'h0000;
               end
            end
            ST_CONV: begin
               conv_cnt <= conv_cnt + 16'h0001;
               if (conv_end) begin
                  auto_cnt <= 16'h0000;
                  phase    <= auto_start ? ST_SAMPLE : ST_IDLE;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control, configuration and mask register fields.
   always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         src_code   <= CTRL_RESET[SRC_HI:SRC_LO];
         group_sel  <= CTRL_RESET[GROUP_BIT];
         simultaneous_sample_sel     <= CTRL_RESET[SIMSEL_BIT];
         auto_start <= CTRL_RESET[AUTO_START_SAMPLING_BIT];
         chan_count <= CFG_RESET[CHCNT_HI:CHCNT_LO];
         twelve_bit <= CFG_RESET[TWELVE_BIT];
         mask       <= MASK_RESET;
      end else begin
         if (wr_ctrl) begin
            src_code   <= WDATA_IN[SRC_HI:SRC_LO];
            group_sel  <= WDATA_IN[GROUP_BIT];
            simultaneous_sample_sel     <= WDATA_IN[SIMSEL_BIT];
            auto_start <= WDATA_IN[AUTO_START_SAMPLING_BIT];
         end
         if (WR_IN && ADDR_IN == CFG_OFFSET) begin
            chan_count <= WDATA_IN[CHCNT_HI:CHCNT_LO];
            twelve_bit <= WDATA_IN[TWELVE_BIT];
         end
         if (WR_IN && ADDR_IN == MASK_OFFSET)
            mask <= WDATA_IN[EV_WIDTH-1:0];
      end
   end

   // Sample enable bit: hardware clear on trigger, hardware set on auto-start.
   always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
      if (RST_IN)
         sample_en <= CTRL_RESET[SAMPLE_ENABLE_BIT_BIT];
      else if (start_conv)
         sample_en <= 1'b0;
      else if (conv_end && auto_start)
         sample_en <= 1'b1;
      else if (wr_ctrl && phase != ST_CONV)
         sample_en <= WDATA_IN[SAMPLE_ENABLE_BIT_BIT];
   end

   // Done flag: set wins over a software clear; software can never set it.
   always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
      if (RST_IN)
         done <= CTRL_RESET[DONE_BIT];
      else if (conv_end)
         done <= 1'b1;
      else if (start_conv)
         done <= 1'b0;
      else if (wr_ctrl && !WDATA_IN[DONE_BIT])
         done <= 1'b0; // Only the flag changes, the sequencer is untouched.
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky event status, write one to clear; a new event wins over the clear.
   always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
      if (RST_IN)
         status <= '0;
      else if (WR_IN && ADDR_IN == STATUS_OFFSET)
         status <= (status & ~WDATA_IN[EV_WIDTH-1:0]) | events;
      else
         status <= status | events;
   end

   always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
      if (RST_IN)
         IRQ_OUT <= 1'b0;
      else
         IRQ_OUT <= |(status & mask);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Converter side outputs, registered.
   always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
      if (RST_IN)
         SH_OUT <= '0;
      else begin
         SH_OUT.sampling      <= sample_en;
         SH_OUT.convert_start <= start_conv;
         unique case (chan_count)
            2'b00:   SH_OUT.channel_enable <= 4'h1;
            2'b01:   SH_OUT.channel_enable <= 4'h3;
            default: SH_OUT.channel_enable <= 4'hf;
         endcase
         // Together mask: all enabled channels at once, or none meaning one by one.
         if (eff_simultaneous_sample_sel)
            SH_OUT.sample_together <= chan_count[1] ? 4'hf : 4'h3;
         else
            SH_OUT.sample_together <= 4'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read port; data valid the cycle after the read strobe.
   always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
      if (RST_IN)
         RDATA_OUT <= 16'h0000;
      else if (RD_IN) begin
         unique case (ADDR_IN)
            CTRL_OFFSET:   RDATA_OUT <= {8'h00, src_code, group_sel, simultaneous_sample_sel && !twelve_bit, auto_start, sample_en, done};
            STATUS_OFFSET: RDATA_OUT <= {13'h0000, status};
            MASK_OFFSET:   RDATA_OUT <= {13'h0000, mask};
            CFG_OFFSET:    RDATA_OUT <= {13'h0000, twelve_bit, chan_count};
            default:       RDATA_OUT <= 16'h0000;
         endcase
      end else
         RDATA_OUT <= 16'h0000;
   end

endmodule

/* File: adc_trig_properties.sv */
// Port-level checks of the sample and convert trigger block.
`timescale 1ns/1ps
module adc_trig_properties
   import adc_trig_pkg::*;
#(
   parameter int CONV_COUNT = CONV_COUNT_DEFAULT
)(
   input wire logic        SYS_CLK_IN,
   input wire logic        RST_IN,
   input wire logic [3:0]  ADDR_IN,
   input wire logic [15:0] WDATA_IN,
   input wire logic        WR_IN,
   input wire logic        RD_IN,
   input wire trig_src_t   TRIG_IN,
   input wire logic [15:0] RDATA_OUT,
   input wire sh_ctrl_t    SH_OUT,
   input wire logic        IRQ_OUT
);
   localparam int CW = CONV_COUNT + 4;
   logic auto_start_sampling;
   wire  ctrl_wr = WR_IN && ADDR_IN == CTRL_OFFSET;
   //////////////////////////////
   // Shadow of the auto-start bit, since the register itself is not visible here.
   always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         auto_start_sampling <= 1'b0;
      end else if (ctrl_wr) begin
         auto_start_sampling <= WDATA_IN[AUTO_START_SAMPLING_BIT];
      end
   end
   default clocking @(posedge SYS_CLK_IN); endclocking
   default disable iff (RST_IN);
   // Software ends sampling in manual mode.
   sequence s_manual_end;
      ctrl_wr && !WDATA_IN[SAMPLE_ENABLE_BIT_BIT] && WDATA_IN[7:4] == 4'h0 && SH_OUT.sampling;
   endsequence
   // The lag of the sampling output is skipped before looking for the restart.
   sequence s_restart;
      ##[3:CW] SH_OUT.sampling;
   endsequence
   //////////////////////////////
   a_start_pulse: assert property (SH_OUT.convert_start |=> !SH_OUT.convert_start)
      else $error("convert start longer than one cycle");
   a_start_holds: assert property (SH_OUT.convert_start |-> ##[0:2] !SH_OUT.sampling)
      else $error("amplifiers still sampling after start");
   a_start_from_sample_enable_bit: assert property (SH_OUT.convert_start |-> $past(SH_OUT.sampling) || $past(SH_OUT.sampling, 2))
      else $error("conversion started outside sampling");
   a_manual_end: assert property (s_manual_end |-> ##[1:3] SH_OUT.convert_start)
      else $error("manual clear did not start conversion");
   a_auto_restart: assert property (SH_OUT.convert_start && auto_start_sampling |-> s_restart)
      else $error("sampling not restarted after conversion");
   a_no_self_start: assert property ($rose(SH_OUT.sampling) && !auto_start_sampling |-> $past(ctrl_wr) || $past(ctrl_wr, 2) || $past(ctrl_wr, 3))
      else $error("sampling began without software");
   a_together_code: assert property (SH_OUT.sample_together inside {4'h0, 4'h3, 4'hf})
      else $error("illegal simultaneous channel set");
   a_read_idle: assert property (!$past(RD_IN) |-> RDATA_OUT == 16'h0000)
      else $error("read data outside read slot");
endmodule

/* File: adc_trig_sources.sv */
// Behavioural model of the on-chip trigger sources.
`timescale 1ns/1ps
module adc_trig_sources
   import adc_trig_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       fire_in,
   input  wire logic       group_in,
   input  wire logic [2:0] code_in,
   output trig_src_t       src_out
);
   trig_src_t pend;
   // Pick the one source that the group and code name, or every source for group 1 code 7.
   always_comb begin
      pend = '0;
      case ({group_in, code_in})
         4'h1: pend.ext_int0_pin = 1'b1;
         4'h2: pend.timer3_compare = 1'b1;
         4'h3: pend.pwm_primary_event = 1'b1;
         4'h4: pend.timer5_compare = 1'b1;
         4'h5: pend.pwm_secondary_event = 1'b1;
         4'h6: pend.charge_time_unit = 1'b1;
         4'h8: pend.pwm_gen_primary = 3'h1;
         4'h9: pend.pwm_gen_primary = 3'h2;
         4'ha: pend.pwm_gen_primary = 3'h4;
         4'hb: pend.pattern_trigger_out_12 = 1'b1;
         4'hc: pend.pattern_trigger_out_13 = 1'b1;
         4'hd: pend.pattern_trigger_out_14 = 1'b1;
         4'he: pend.pattern_trigger_out_15 = 1'b1;
         4'hf: pend = '1; // Everything fires, so a reserved code that decodes anything shows.
         default: pend = '0;
      endcase
   end
   // Sources come from clocked blocks, so they change on the clock.
   always_ff @(posedge clk_in) begin
      src_out <= fire_in ? pend : '0;
   end
endmodule

/* File: tb_top.sv */
// Self-checking bench for the sample and convert trigger block.
`timescale 1ns/1ps
module tb_top
   import adc_trig_pkg::*;
;
   localparam int AC = 4;
   localparam int CC = 6;
   localparam logic [15:0] CFGS [5] = '{16'h0002, 16'h0001, 16'h0000, 16'h0006, 16'h0002};
   localparam logic [15:0] CTLS [5] = '{16'h000a, 16'h000a, 16'h000a, 16'h000a, 16'h0002};
   localparam logic [3:0]  TOG  [5] = '{4'hf, 4'h3, 4'h0, 4'h0, 4'h0};
   localparam logic [3:0]  CHEN [5] = '{4'hf, 4'h3, 4'h1, 4'hf, 4'hf};
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic        wstb = 1'b0;
   logic        rstb = 1'b0;
   logic        fire = 1'b0;
   logic        grp = 1'b0;
   logic [2:0]  code = 3'h0;
   logic [15:0] rdata;
   sh_ctrl_t    sh;
   logic        irq;
   trig_src_t   src;
   int          n_errors = 0;
   int          cmp_count = 0;
   // A 40 ns clock.
   always #20 clk = ~clk;
   adc_sample_convert_trigger #(.AUTO_COUNT(AC), .CONV_COUNT(CC)) DUT (.SYS_CLK_IN(clk), .RST_IN(rst),
      .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wstb), .RD_IN(rstb), .TRIG_IN(src), .RDATA_OUT(rdata),
      .SH_OUT(sh), .IRQ_OUT(irq));
   adc_trig_sources u_src (.clk_in(clk), .fire_in(fire), .group_in(grp), .code_in(code), .src_out(src));
   //////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wstb <= 1'b1;
      @(posedge clk);
      wstb <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe, so they are taken just past that edge.
   task automatic rreg(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rstb <= 1'b1;
      @(posedge clk);
      rstb <= 1'b0;
      #1 d = rdata;
   endtask
   // Looks first just past the current edge, so a start pulse launched at that very edge is not missed.
   task automatic see_start(input int n, output logic seen);
      seen = 1'b0;
      repeat (n) begin
         #1 if (sh.convert_start === 1'b1) seen = 1'b1;
         @(posedge clk);
      end
   endtask
   task automatic do_reset();
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
   endtask
   task automatic trig_case(input logic g, input logic [2:0] c, input logic sample_enable_bit, input logic exp);
      logic s;
      wreg(CTRL_OFFSET, {8'h00, c, g, 2'b00, sample_enable_bit, 1'b0});
      @(posedge clk);
      grp <= g;
      code <= c;
      fire <= 1'b1;
      see_start(5, s);
      @(posedge clk);
      fire <= 1'b0;
      chk({15'h0, s}, {15'h0, exp});
      repeat (CC + 2) @(posedge clk);
   endtask
   //////////////////////////////
   task automatic t_regs();
      logic [15:0] d;
      rreg(CTRL_OFFSET, d);
      chk(d, CTRL_RESET);
      rreg(CFG_OFFSET, d);
      chk(d, CFG_RESET);
      rreg(MASK_OFFSET, d);
      chk(d, {13'h0, MASK_RESET});
      rreg(4'h9, d);
      chk(d, 16'h0000);
      $display("register test done");
   endtask
   task automatic t_manual();
      logic [15:0] d;
      logic s;
      wreg(MASK_OFFSET, 16'h0001);
      wreg(CTRL_OFFSET, 16'h0002);
      repeat (2) @(posedge clk);
      #1 chk({15'h0, sh.sampling}, 16'h0001);
      wreg(CTRL_OFFSET, 16'h0000);
      see_start(3, s);
      chk({15'h0, s}, 16'h0001);
      repeat (CC + 2) @(posedge clk);
      rreg(CTRL_OFFSET, d);
      chk(d & 16'h0003, 16'h0001);
      rreg(STATUS_OFFSET, d);
      chk(d, 16'h0003);
      chk({15'h0, irq}, 16'h0001);
      wreg(MASK_OFFSET, 16'h0000);
      repeat (3) @(posedge clk);
      #1 chk({15'h0, irq}, 16'h0000);
      wreg(STATUS_OFFSET, 16'h0007);
      wreg(MASK_OFFSET, 16'h0001);
      repeat (3) @(posedge clk);
      #1 chk({15'h0, irq}, 16'h0000);
      // Software only ever writes zero to the done flag, so every control write here clears it.
      wreg(CTRL_OFFSET, 16'h0002);
      rreg(CTRL_OFFSET, d);
      chk(d & 16'h0003, 16'h0002);
      wreg(CTRL_OFFSET, 16'h0000);
      rreg(CTRL_OFFSET, d);
      chk(d & 16'h0003, 16'h0000);
      wreg(CTRL_OFFSET, 16'h0000);
      repeat (CC + 2) @(posedge clk);
      rreg(CTRL_OFFSET, d);
      chk(d & 16'h0001, 16'h0001);
      $display("manual test done");
   endtask
   task automatic t_trig();
      logic [15:0] d;
      for (int i = 1; i < 15; i++) begin
         if (i != 7) begin
            trig_case(i[3], i[2:0], 1'b1, 1'b1);
         end
      end
      trig_case(1'b0, 3'h2, 1'b0, 1'b0);
      rreg(STATUS_OFFSET, d);
      chk(d & 16'h0004, 16'h0004);
      trig_case(1'b1, 3'h7, 1'b1, 1'b0);
      do_reset();
      $display("trigger test done");
   endtask
   task automatic t_auto();
      logic        s;
      logic [15:0] d;
      wreg(CTRL_OFFSET, 16'h00e6);
      see_start(AC + 4, s);
      chk({15'h0, s}, 16'h0001);
      see_start(CC + AC + 6, s);
      chk({15'h0, s}, 16'h0001);
      // The third start has just cleared the done flag that the second conversion set.
      rreg(CTRL_OFFSET, d);
      chk(d & 16'h0003, 16'h0000);
      do_reset(); // Auto mode is left by reset, never by clearing the done flag.
      $display("auto test done");
   endtask
   task automatic t_sim();
      logic [15:0] d;
      for (int i = 0; i < 5; i++) begin
         wreg(CFG_OFFSET, CFGS[i]);
         wreg(CTRL_OFFSET, CTLS[i]);
         repeat (2) @(posedge clk);
         #1 chk({12'h0, sh.sample_together}, {12'h0, TOG[i]});
         chk({12'h0, sh.channel_enable}, {12'h0, CHEN[i]});
         rreg(CTRL_OFFSET, d);
         chk(d & 16'h0008, (i == 3) ? 16'h0000 : (CTLS[i] & 16'h0008));
         wreg(CTRL_OFFSET, 16'h0000);
         repeat (CC + 3) @(posedge clk);
      end
      $display("simultaneous test done");
   endtask
   task automatic conclude();
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Main sequence.
   initial begin
      do_reset();
      t_regs();
      t_manual();
      t_trig();
      t_auto();
      t_sim();
      conclude();
   end
   // The tests need about 450 cycles; this limit leaves a wide margin.
   initial begin
      #(3000 * 40);
      n_errors++;
      conclude();
   end
endmodule
bind adc_sample_convert_trigger adc_trig_properties #(.CONV_COUNT(CONV_COUNT)) u_props (.SYS_CLK_IN(SYS_CLK_IN),
   .RST_IN(RST_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .TRIG_IN(TRIG_IN),
   .RDATA_OUT(RDATA_OUT), .SH_OUT(SH_OUT), .IRQ_OUT(IRQ_OUT));
